// >>> hw/cis_pkg.sv
package cis_pkg;

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam logic [11:0] OFS_IRQ_CONTROL_REG  = 12'h000;
  localparam logic [11:0] OFS_PERIPH_FLAG_REGS = 12'h004;
  localparam logic [11:0] OFS_PERIPH_EN_REGS   = 12'h008;
  localparam logic [11:0] OFS_CONFIG           = 12'h00C;
  localparam logic [11:0] OFS_STATUS           = 12'h010;
  localparam logic [11:0] OFS_SHADOW           = 12'h014;

  // ----------------------------------------------------------------------------
  // Control and configuration register fields
  // ----------------------------------------------------------------------------
  localparam int BIT_GLOBAL_IRQ_ENABLE       = 7;
  localparam int BIT_PERIPHERAL_GROUP_ENABLE = 6;
  localparam int BIT_CORE_EN_LSB             = 3;
  localparam int BIT_CORE_FLAG_LSB           = 0;
  localparam int CORE_SRC_NUM                = 3;
  localparam int CORE_IDX_TIMER              = 2;
  localparam int CORE_IDX_EXT_PIN            = 1;
  localparam int CORE_IDX_CHANGE             = 0;
  localparam int BIT_EXT_PIN_EDGE_SELECT     = 0;

  // ----------------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------------
  localparam logic [7:0]  RST_IRQ_CONTROL_REG  = 8'h00;
  localparam logic [7:0]  RST_PERIPH_EN_REGS   = 8'h00;
  localparam logic        RST_EDGE_SELECT      = 1'b1;
  localparam logic [14:0] IRQ_VECTOR           = 15'h0004;
  localparam logic [1:0]  PHASE_Q1             = 2'h0;
  localparam logic [1:0]  PHASE_Q4             = 2'h3;
  localparam int          PHASES_PER_CYCLE     = 4;
  localparam int          CLK_PERIOD_NS        = 20;
  localparam int          INSTR_CYCLE_TIME_NS  = PHASES_PER_CYCLE * CLK_PERIOD_NS;

  // Gray-coded entry sequence; one state per instruction cycle.
  typedef enum logic [1:0]
  {
    CIS_IDLE   = 2'b00,
    CIS_ENTER  = 2'b01,
    CIS_DWELL  = 2'b11,
    CIS_VECTOR = 2'b10
  } cis_state_t;

endpackage

// >>> hw/cis_flag_if.sv
`timescale 1ns/100ps
interface cis_flag_if #(parameter int N = 8);
  logic [N-1:0] set;
  logic         wr_en;
  logic [N-1:0] wr_data;
  logic [N-1:0] flags;

  modport bank (input set, input wr_en, input wr_data, output flags);
  modport ctrl (output set, output wr_en, output wr_data, input flags);
endinterface

// >>> hw/cis_flag_bank.sv
`timescale 1ns/100ps
module cis_flag_bank #(parameter int N = 8)
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Flag access
  cis_flag_if.bank  fl
);

  // A hardware set in the same cycle as a software write of zero wins.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fl.flags <= '0;
    else if (fl.wr_en)
      fl.flags <= fl.wr_data | fl.set;
    else
      fl.flags <= fl.flags | fl.set;
  end

endmodule

// >>> hw/cis_sequencer.sv
`timescale 1ns/100ps
module cis_sequencer #(parameter int PERIPH_NUM = 8)
(
  // Clock and reset
  input  wire logic                  I_SYS_CLK,
  input  wire logic                  I_RSTN,
  // APB slave
  input  wire logic                  I_PSEL,
  input  wire logic                  I_PENABLE,
  input  wire logic                  I_PWRITE,
  input  wire logic [11:0]           I_PADDR,
  input  wire logic [31:0]           I_PWDATA,
  output logic      [31:0]           O_PRDATA,
  output logic                       O_PREADY,
  output logic                       O_PSLVERR,
  // Interrupt sources
  input  wire logic                  I_TIMER_EVT,
  input  wire logic                  I_CHANGE_EVT,
  input  wire logic                  I_EXT_PIN,
  input  wire logic [PERIPH_NUM-1:0] I_PERIPH_EVT,
  // Processor core
  input  wire logic [14:0]           I_CPU_PC,
  input  wire logic [31:0]           I_CPU_CONTEXT,
  input  wire logic                  I_RETURN_INSTR,
  input  wire logic                  I_SLEEPING,
  output logic      [1:0]            O_Q_PHASE,
  output logic                       O_FLUSH,
  output logic                       O_PUSH,
  output logic      [14:0]           O_PUSH_PC,
  output logic                       O_LOAD_PC,
  output logic      [14:0]           O_NEW_PC,
  output logic                       O_POP,
  output logic                       O_RESTORE,
  output logic      [31:0]           O_RESTORE_CONTEXT,
  output logic                       O_WAKE
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic [1:0] rst_sync;
  logic       rst_n;

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end

  assign rst_n = rst_sync[1];

  // --------------------------------------------------------------------------
  // Quarter phases
  // --------------------------------------------------------------------------
  logic [1:0] phase;
  logic       at_q1;
  logic       at_q4;

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      phase <= cis_pkg::PHASE_Q1;
    else
      phase <= phase + 2'h1;
  end

  assign at_q1 = (phase == cis_pkg::PHASE_Q1);
  assign at_q4 = (phase == cis_pkg::PHASE_Q4);

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  logic access;
  logic wr;
  logic hit_ctrl;
  logic hit_pflag;
  logic hit_pen;
  logic hit_cfg;
  logic hit_stat;
  logic hit_shadow;
  logic mapped;

  // One wait state: the answer comes on the second access-phase edge.
  assign access     = I_PSEL && I_PENABLE && !O_PREADY;
  assign wr         = access && I_PWRITE;
  assign hit_ctrl   = (I_PADDR == cis_pkg::OFS_IRQ_CONTROL_REG);
  assign hit_pflag  = (I_PADDR == cis_pkg::OFS_PERIPH_FLAG_REGS);
  assign hit_pen    = (I_PADDR == cis_pkg::OFS_PERIPH_EN_REGS);
  assign hit_cfg    = (I_PADDR == cis_pkg::OFS_CONFIG);
  assign hit_stat   = (I_PADDR == cis_pkg::OFS_STATUS);
  assign hit_shadow = (I_PADDR == cis_pkg::OFS_SHADOW);
  assign mapped     = hit_ctrl | hit_pflag | hit_pen | hit_cfg | hit_stat | hit_shadow;

  // --------------------------------------------------------------------------
  // Enables and configuration
  // --------------------------------------------------------------------------
  logic                               global_irq_enable;
  logic                               peripheral_group_enable;
  logic [cis_pkg::CORE_SRC_NUM-1:0]   core_en;
  logic [PERIPH_NUM-1:0]              peripheral_enable_regs;
  logic                               ext_pin_edge_select;
  cis_pkg::cis_state_t                state;
  logic                               enter;

  // Hardware clear on entry outranks a software write in the same cycle.
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      global_irq_enable <= cis_pkg::RST_IRQ_CONTROL_REG[cis_pkg::BIT_GLOBAL_IRQ_ENABLE];
    else if (enter)
      global_irq_enable <= 1'b0;
    else if (I_RETURN_INSTR)
      global_irq_enable <= 1'b1;
    else if (wr && hit_ctrl)
      global_irq_enable <= I_PWDATA[cis_pkg::BIT_GLOBAL_IRQ_ENABLE];
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      peripheral_group_enable <=
        cis_pkg::RST_IRQ_CONTROL_REG[cis_pkg::BIT_PERIPHERAL_GROUP_ENABLE];
      core_en                 <= '0;
    end
    else if (wr && hit_ctrl)
    begin
      peripheral_group_enable <= I_PWDATA[cis_pkg::BIT_PERIPHERAL_GROUP_ENABLE];
      core_en <= I_PWDATA[cis_pkg::BIT_CORE_EN_LSB +: cis_pkg::CORE_SRC_NUM];
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      peripheral_enable_regs <= cis_pkg::RST_PERIPH_EN_REGS[PERIPH_NUM-1:0];
    else if (wr && hit_pen)
      peripheral_enable_regs <= I_PWDATA[PERIPH_NUM-1:0];
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      ext_pin_edge_select <= cis_pkg::RST_EDGE_SELECT;
    else if (wr && hit_cfg)
      ext_pin_edge_select <= I_PWDATA[cis_pkg::BIT_EXT_PIN_EDGE_SELECT];
  end

  // --------------------------------------------------------------------------
  // External pin edge capture
  // --------------------------------------------------------------------------
  logic pin_d;
  logic pin_seen;
  logic pin_edge;
  logic edge_pending;
  logic ext_set;

  // No edge on the first sample after reset, since the pin may already rest high.
  assign pin_edge = pin_seen && (ext_pin_edge_select ? (I_EXT_PIN && !pin_d)
                                                     : (!I_EXT_PIN && pin_d));
  // The flag may only change during Q4 and Q1, so a captured edge waits there.
  assign ext_set  = (edge_pending || pin_edge) && (at_q4 || at_q1);

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_d        <= 1'b0;
      pin_seen     <= 1'b0;
      edge_pending <= 1'b0;
    end
    else
    begin
      pin_d        <= I_EXT_PIN;
      pin_seen     <= 1'b1;
      edge_pending <= (edge_pending || pin_edge) && !ext_set;
    end
  end

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  cis_flag_if #(.N(cis_pkg::CORE_SRC_NUM)) core_fl ();
  cis_flag_if #(.N(PERIPH_NUM))            periph_fl ();

  always_comb
  begin
    core_fl.set = '0;
    core_fl.set[cis_pkg::CORE_IDX_TIMER]   = I_TIMER_EVT;
    core_fl.set[cis_pkg::CORE_IDX_EXT_PIN] = ext_set;
    core_fl.set[cis_pkg::CORE_IDX_CHANGE]  = I_CHANGE_EVT;
  end

  assign core_fl.wr_en     = wr && hit_ctrl;
  assign core_fl.wr_data   = I_PWDATA[cis_pkg::BIT_CORE_FLAG_LSB +: cis_pkg::CORE_SRC_NUM];
  assign periph_fl.set     = I_PERIPH_EVT;
  assign periph_fl.wr_en   = wr && hit_pflag;
  assign periph_fl.wr_data = I_PWDATA[PERIPH_NUM-1:0];

  cis_flag_bank #(.N(cis_pkg::CORE_SRC_NUM)) u_core_flags
  (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (rst_n),
    .fl      (core_fl)
  );

  cis_flag_bank #(.N(PERIPH_NUM)) u_periph_flags
  (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (rst_n),
    .fl      (periph_fl)
  );

  // --------------------------------------------------------------------------
  // Request and wake
  // --------------------------------------------------------------------------
  logic enabled_any;
  logic req;
  logic sleep_d;
  logic wake_hold;

  assign enabled_any = |(core_fl.flags & core_en) ||
                       (peripheral_group_enable &&
                        |(periph_fl.flags & peripheral_enable_regs));
  assign req         = global_irq_enable && enabled_any;

  // After wake the next instruction runs for one full cycle before entry.
  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_d   <= 1'b0;
      wake_hold <= 1'b0;
      O_WAKE    <= 1'b0;
    end
    else
    begin
      sleep_d <= I_SLEEPING;
      O_WAKE  <= I_SLEEPING && enabled_any && !O_WAKE;
      if (sleep_d && !I_SLEEPING)
        wake_hold <= 1'b1;
      else if (at_q1)
        wake_hold <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Entry sequence
  // --------------------------------------------------------------------------
  // Sampling only at Q1 and always flushing keeps the latency fixed in
  // instruction cycles, whatever the length of the interrupted instruction.
  // The wake cycle itself is blocked too, before the hold flop has caught it.
  assign enter = at_q1 && (state == cis_pkg::CIS_IDLE) && req && !wake_hold
                 && !I_SLEEPING && !sleep_d;

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      state <= cis_pkg::CIS_IDLE;
    else if (enter)
      state <= cis_pkg::CIS_ENTER;
    else if (at_q1)
    begin
      case (state)
        cis_pkg::CIS_ENTER:  state <= cis_pkg::CIS_DWELL;
        cis_pkg::CIS_DWELL:  state <= cis_pkg::CIS_VECTOR;
        cis_pkg::CIS_VECTOR: state <= cis_pkg::CIS_IDLE;
        default:             state <= cis_pkg::CIS_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_FLUSH   <= 1'b0;
      O_PUSH    <= 1'b0;
      O_PUSH_PC <= '0;
      O_LOAD_PC <= 1'b0;
      O_NEW_PC  <= '0;
    end
    else
    begin
      O_FLUSH   <= enter;
      O_PUSH    <= enter;
      O_LOAD_PC <= at_q1 && (state == cis_pkg::CIS_DWELL);
      if (enter)
        O_PUSH_PC <= I_CPU_PC;
      if (at_q1 && (state == cis_pkg::CIS_DWELL))
        O_NEW_PC <= cis_pkg::IRQ_VECTOR;
    end
  end

  // --------------------------------------------------------------------------
  // Context shadow and return
  // --------------------------------------------------------------------------
  logic [31:0] shadow;

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      shadow <= '0;
    else if (enter)
      shadow <= I_CPU_CONTEXT;
    else if (wr && hit_shadow)
      shadow <= I_PWDATA;
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_POP             <= 1'b0;
      O_RESTORE         <= 1'b0;
      O_RESTORE_CONTEXT <= '0;
    end
    else
    begin
      O_POP     <= I_RETURN_INSTR;
      O_RESTORE <= I_RETURN_INSTR;
      if (I_RETURN_INSTR)
        O_RESTORE_CONTEXT <= shadow;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
      O_Q_PHASE <= cis_pkg::PHASE_Q1;
    else
      O_Q_PHASE <= phase + 2'h1;
  end

  // --------------------------------------------------------------------------
  // APB answer
  // --------------------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb
  begin
    next_prdata = '0;
    if (hit_ctrl)
      next_prdata[7:0] = {global_irq_enable, peripheral_group_enable, core_en,
                          core_fl.flags};
    else if (hit_pflag)
      next_prdata[PERIPH_NUM-1:0] = periph_fl.flags;
    else if (hit_pen)
      next_prdata[PERIPH_NUM-1:0] = peripheral_enable_regs;
    else if (hit_cfg)
      next_prdata[0] = ext_pin_edge_select;
    else if (hit_stat)
      next_prdata[5:0] = {wake_hold, req, state, phase};
    else if (hit_shadow)
      next_prdata = shadow;
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA  <= '0;
    end
    else
    begin
      O_PREADY  <= access;
      O_PSLVERR <= access && !mapped;
      if (access && !I_PWRITE)
        O_PRDATA <= next_prdata;
    end
  end

endmodule

// >>> verification/cis_sequencer_checker.sv
`timescale 1ns/100ps
module cis_sequencer_checker
(
  // Clock and reset
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RSTN,
  // Core side
  input  wire logic [14:0] I_CPU_PC,
  input  wire logic        I_RETURN_INSTR,
  input  wire logic        I_SLEEPING,
  input  wire logic [1:0]  O_Q_PHASE,
  input  wire logic        O_FLUSH,
  input  wire logic        O_PUSH,
  input  wire logic [14:0] O_PUSH_PC,
  input  wire logic        O_LOAD_PC,
  input  wire logic [14:0] O_NEW_PC,
  input  wire logic        O_POP,
  input  wire logic        O_RESTORE
);
  // --------------------------------------------------------------------------
  // Entry and return sequencing
  // --------------------------------------------------------------------------
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);

  property p_entry_push;
    O_PUSH |-> O_FLUSH && O_PUSH_PC == $past(I_CPU_PC);
  endproperty
  a_entry_push: assert property (p_entry_push)
    else $error("entry push without flush or with a wrong return address");

  property p_vector_load;
    O_PUSH |=> !O_LOAD_PC [*7] ##1 (O_LOAD_PC && O_NEW_PC == cis_pkg::IRQ_VECTOR);
  endproperty
  a_vector_load: assert property (p_vector_load)
    else $error("vector load missing, early or not at the vector");

  property p_load_cause;
    O_LOAD_PC |-> $past(O_PUSH, 8);
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("vector load without a matching entry");

  property p_take_q1;
    O_PUSH |-> $past(O_Q_PHASE) == cis_pkg::PHASE_Q1 && !$past(I_SLEEPING);
  endproperty
  a_take_q1: assert property (p_take_q1)
    else $error("entry taken outside the first phase or while asleep");

  property p_no_reentry;
    O_PUSH |=> !O_PUSH [*8];
  endproperty
  a_no_reentry: assert property (p_no_reentry)
    else $error("second entry inside a running entry");

  property p_phase_wrap;
    O_Q_PHASE == cis_pkg::PHASE_Q4 |=> O_Q_PHASE == 2'h0 ##1 O_Q_PHASE == 2'h1
      ##1 O_Q_PHASE == 2'h2 ##1 O_Q_PHASE == cis_pkg::PHASE_Q4;
  endproperty
  a_phase_wrap: assert property (p_phase_wrap)
    else $error("quarter phases out of order");

  property p_return;
    I_RETURN_INSTR |=> O_POP && O_RESTORE;
  endproperty
  a_return: assert property (p_return)
    else $error("return did not pop and restore");

  property p_pop_cause;
    O_POP |-> $past(I_RETURN_INSTR);
  endproperty
  a_pop_cause: assert property (p_pop_cause)
    else $error("pop without a return");
endmodule

bind cis_sequencer cis_sequencer_checker u_checker
(
  .I_SYS_CLK, .I_RSTN, .I_CPU_PC, .I_RETURN_INSTR, .I_SLEEPING, .O_Q_PHASE,
  .O_FLUSH, .O_PUSH, .O_PUSH_PC, .O_LOAD_PC, .O_NEW_PC, .O_POP, .O_RESTORE
);

// >>> verification/cis_core_model.sv
`timescale 1ns/100ps
module cis_core_model
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // Sequencer requests
  input  wire logic        i_push,
  input  wire logic [14:0] i_push_pc,
  input  wire logic        i_load_pc,
  input  wire logic [14:0] i_new_pc,
  input  wire logic        i_pop,
  // Bench command
  input  wire logic        i_do_return,
  // Core state
  output logic      [14:0] o_pc,
  output logic      [31:0] o_context,
  output logic      [31:0] o_saved_ctx,
  output logic             o_return_instr
);
  logic [14:0] stack_top;
  logic [31:0] ctx_d;

  // The context changes every cycle, so a late or early save shows up.
  assign o_context = {17'h0, o_pc} ^ 32'hC3C3_0000;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_pc <= 15'h0000;
      stack_top <= 15'h0000;
      ctx_d <= 32'h0;
      o_saved_ctx <= 32'h0;
      o_return_instr <= 1'b0;
    end
    else
    begin
      ctx_d <= o_context;
      o_return_instr <= i_do_return;
      o_pc <= o_pc + 15'h0001;
      if (i_push)
      begin
        stack_top <= i_push_pc;
        o_saved_ctx <= ctx_d;
      end
      if (i_load_pc)
        o_pc <= i_new_pc;
      if (i_pop)
        o_pc <= stack_top;
    end
  end
endmodule

// >>> verification/cis_sequencer_test.sv
`timescale 1ns/100ps
module cis_sequencer_test;
  localparam logic [11:0] A_CTL = cis_pkg::OFS_IRQ_CONTROL_REG;
  localparam logic [11:0] A_FLG = cis_pkg::OFS_PERIPH_FLAG_REGS;
  localparam logic [11:0] A_PEN = cis_pkg::OFS_PERIPH_EN_REGS;
  localparam logic [11:0] A_CFG = cis_pkg::OFS_CONFIG;
  localparam logic [11:0] A_SHD = cis_pkg::OFS_SHADOW;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic        timer_evt, change_evt, ext_pin, ret_instr, sleeping, do_ret;
  logic        flush, push, load_pc, pop, restore, wake;
  logic [1:0]  q_phase;
  logic [7:0]  periph_evt;
  logic [11:0] paddr;
  logic [14:0] cpu_pc, push_pc, new_pc;
  logic [31:0] pwdata, prdata, restore_ctx, cpu_ctx, saved_ctx, popped_ctx, exp_ctx, r;
  int          n_mismatch, total_checks, n_entry, n_pop, n_wake, lat;
  event        abort;

  always #(cis_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  cis_sequencer #(.PERIPH_NUM(8)) dut
  (
    .I_SYS_CLK(clk), .I_RSTN(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TIMER_EVT(timer_evt),
    .I_CHANGE_EVT(change_evt), .I_EXT_PIN(ext_pin), .I_PERIPH_EVT(periph_evt),
    .I_CPU_PC(cpu_pc), .I_CPU_CONTEXT(cpu_ctx), .I_RETURN_INSTR(ret_instr),
    .I_SLEEPING(sleeping), .O_Q_PHASE(q_phase), .O_FLUSH(flush), .O_PUSH(push),
    .O_PUSH_PC(push_pc), .O_LOAD_PC(load_pc), .O_NEW_PC(new_pc), .O_POP(pop),
    .O_RESTORE(restore), .O_RESTORE_CONTEXT(restore_ctx), .O_WAKE(wake)
  );

  cis_core_model core
  (
    .i_clk(clk), .i_rst_n(rst_n), .i_push(push), .i_push_pc(push_pc),
    .i_load_pc(load_pc), .i_new_pc(new_pc), .i_pop(pop), .i_do_return(do_ret),
    .o_pc(cpu_pc), .o_context(cpu_ctx), .o_saved_ctx(saved_ctx),
    .o_return_instr(ret_instr)
  );

  always @(posedge clk)
  begin
    if (push === 1'b1)
      n_entry <= n_entry + 1;
    if (pop === 1'b1)
      n_pop <= n_pop + 1;
    if (pop === 1'b1)
      popped_ctx <= restore_ctx;
    if (wake === 1'b1)
      n_wake <= n_wake + 1;
  end

  // --------------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task time_out;
    n_mismatch++;
    $display("wrong value at %0t: wait ran out", $time);
    -> abort;
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Called just after a rising edge; returns one idle cycle after the answer.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      time_out();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    check(rd, exp);
  endtask

  task fire(input logic t, input logic c, input logic [7:0] p);
    timer_evt <= t;
    change_evt <= c;
    periph_evt <= p;
    @(posedge clk);
    timer_evt <= 1'b0;
    change_evt <= 1'b0;
    periph_evt <= 8'h00;
    @(posedge clk);
  endtask

  task ret;
    do_ret <= 1'b1;
    @(posedge clk);
    do_ret <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task wait_entry(input int target);
    int n;
    n = 0;
    while (n_entry < target && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 40)
      time_out();
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, timer_evt, change_evt, ext_pin, sleeping, do_ret} = '0;
    paddr = '0;
    pwdata = '0;
    periph_evt = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(A_CTL, 32'h0);
    rd_chk(A_PEN, 32'h0);
    rd_chk(A_CFG, 32'h1);
    apb(1'b0, 12'h018, 32'h0, r, e);
    check({31'h0, e}, 32'h1);
    check(r, 32'h0);
    fire(1'b1, 1'b1, 8'hA5);
    fire(1'b1, 1'b1, 8'hA5);
    repeat (2) @(posedge clk);
    rd_chk(A_CTL, 32'h05);
    rd_chk(A_FLG, 32'hA5);
    wr(A_FLG, 32'h0);
    rd_chk(A_FLG, 32'h0);
    for (int s = 1; s >= 0; s--)
    begin
      wr(A_CFG, 32'(s));
      ext_pin <= s[0];
      repeat (8) @(posedge clk);
      wr(A_CTL, 32'h0);
      ext_pin <= ~s[0];
      repeat (8) @(posedge clk);
      rd_chk(A_CTL, 32'h0);
      ext_pin <= s[0];
      repeat (8) @(posedge clk);
      rd_chk(A_CTL, 32'h2);
    end
    wr(A_CTL, 32'h0);
    wr(A_PEN, 32'h08);
    fire(1'b0, 1'b0, 8'h08);
    wr(A_CTL, 32'h80);
    repeat (20) @(posedge clk);
    check(32'(n_entry), 32'h0);
    wr(A_CTL, 32'hC0);
    wait_entry(1);
    rd_chk(A_CTL, 32'h40);
    rd_chk(A_SHD, saved_ctx);
    exp_ctx = saved_ctx;
    fire(1'b1, 1'b0, 8'h00);
    repeat (20) @(posedge clk);
    check(32'(n_entry), 32'h1);
    rd_chk(A_CTL, 32'h44);
    ret();
    check(popped_ctx, exp_ctx);
    check(32'(n_pop), 32'h1);
    wait_entry(2);
    wr(A_FLG, 32'h0);
    wr(A_CTL, 32'h40);
    wr(A_SHD, 32'h5A5A_A5A5);
    ret();
    check(popped_ctx, 32'h5A5A_A5A5);
    repeat (20) @(posedge clk);
    check(32'(n_entry), 32'h2);
    rd_chk(A_CTL, 32'hC0);
    wr(A_CFG, 32'h1);
    wr(A_CTL, 32'hF0);
    for (int k = 0; k < 5; k++)
    begin
      repeat (k) @(posedge clk);
      if (k < 4)
        timer_evt <= 1'b1;
      else
        ext_pin <= 1'b1;
      lat = 0;
      do
      begin
        @(posedge clk);
        timer_evt <= 1'b0;
        lat++;
      end
      while (load_pc !== 1'b1 && lat < 30);
      check(32'(lat >= 9 && lat <= (k < 4 ? 16 : 20)), 32'h1);
      wr(A_CTL, 32'h70);
      ret();
    end
    sleeping <= 1'b1;
    fire(1'b1, 1'b0, 8'h00);
    repeat (12) @(posedge clk);
    check(32'(n_entry), 32'h7);
    check(32'(n_wake > 0), 32'h1);
    sleeping <= 1'b0;
    repeat (6) @(posedge clk);
    check(32'(n_entry), 32'h7);
    wait_entry(8);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(A_CTL, 32'h0);
    give_verdict();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    time_out();
  end

  initial
  begin
    @(abort);
    give_verdict();
  end
endmodule
